/* bench/bus_far_side.sv */
/*
 * Far-side model of the shared A and B buses: bench-commanded drivers,
 * the device's drivers, and the resolved level on each bus.
 * Assumes active-low device enables and one clock with the device.
 */
`timescale 1ns/1ps

module bus_far_side (
    input wire logic ref_clk_i,
    input wire logic a_drv_i,
    input wire logic [7:0] a_val_i,
    input wire logic b_drv_i,
    input wire logic [7:0] b_val_i,
    input wire logic [7:0] a_dev_i,
    input wire logic a_oe_n_i,
    input wire logic [7:0] b_dev_i,
    input wire logic b_oe_n_i,
    output logic [7:0] a_bus_o,
    output logic [7:0] b_bus_o
);
    // start from a known level so a floating bus never reads unknown
    logic [7:0] a_flt_ff = 8'h00;
    logic [7:0] b_flt_ff = 8'h00;

    // far driver wins a clash; a bus nobody drives toggles every cycle
    // so a stale value can never pass for a held one
    assign a_bus_o = a_drv_i ? a_val_i : (!a_oe_n_i ? a_dev_i : a_flt_ff);
    assign b_bus_o = b_drv_i ? b_val_i : (!b_oe_n_i ? b_dev_i : b_flt_ff);

    // floating level follows the inverse of the last resolved value
    always_ff @(posedge ref_clk_i) begin
        a_flt_ff <= ~a_bus_o;
        b_flt_ff <= ~b_bus_o;
    end
endmodule : bus_far_side

/* bench/octal_registered_bus_transceiver_test.sv */
/*
 * Self-checking bench of the registered bus transceiver.
 * Assumes the far-side bus model and a wishbone classic register port.
 */
`timescale 1ns/1ps

module octal_registered_bus_transceiver_test;
    import xcvr_pkg::*;

    typedef struct packed {
        logic [3:0] ctl;
        logic ad;
        logic [7:0] av;
        logic bd;
        logic [7:0] bv;
        logic [1:0] oe;
        logic [7:0] ao;
        logic [7:0] bo;
    } row_s;

    logic ref_clk_i = 1'b0;
    logic rst_n_i, cyc, stb, we, a_drv, b_drv, ca, cb, rdy, ce;
    logic [3:0] sel;
    logic [7:0] adr, a_val, b_val, a_bus, b_bus, a_o, b_o;
    logic [31:0] wdat, rdat, rd;
    logic ack, a_oe_n, b_oe_n, cvld;
    cap_s cdat;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    row_s rows[6] = '{
        '{4'h3, 1'b1, 8'h5A, 1'b0, 8'h00, 2'b10, 8'h00, 8'h5A},
        '{4'h7, 1'b1, 8'h5A, 1'b0, 8'h00, 2'b10, 8'h00, 8'h33},
        '{4'h0, 1'b0, 8'h00, 1'b1, 8'hA7, 2'b01, 8'hA7, 8'h00},
        '{4'h8, 1'b0, 8'h00, 1'b1, 8'hA7, 2'b01, 8'hC5, 8'h00},
        '{4'hD, 1'b0, 8'h00, 1'b0, 8'h00, 2'b00, 8'hC5, 8'h33},
        '{4'h2, 1'b0, 8'h00, 1'b0, 8'h00, 2'b11, 8'h00, 8'h00}};

    always #5 ref_clk_i = ~ref_clk_i;

    bus_transceiver u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .a_i(a_bus), .a_o(a_o),
        .a_oe_n_o(a_oe_n), .b_i(b_bus), .b_o(b_o), .b_oe_n_o(b_oe_n),
        .a_side_capture_clock_i(ca), .b_side_capture_clock_i(cb),
        .cap_valid_o(cvld), .cap_data_o(cdat), .cap_ready_i(rdy));

    bus_far_side u_far (.ref_clk_i(ref_clk_i), .a_drv_i(a_drv),
        .a_val_i(a_val), .b_drv_i(b_drv), .b_val_i(b_val),
        .a_dev_i(a_o), .a_oe_n_i(a_oe_n), .b_dev_i(b_o),
        .b_oe_n_i(b_oe_n), .a_bus_o(a_bus), .b_bus_o(b_bus));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    // one classic cycle; request held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge ref_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= a;
        wdat <= d;
        do @(posedge ref_clk_i); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic drv(input logic ad, input logic [7:0] av,
        input logic bd, input logic [7:0] bv);
        a_drv <= ad;
        a_val <= av;
        b_drv <= bd;
        b_val <= bv;
        repeat (2) @(posedge ref_clk_i);
    endtask : drv

    // capture clocks rise together, then rest low
    task automatic cap(input logic pa, input logic pb);
        @(posedge ref_clk_i);
        ca <= pa;
        cb <= pb;
        @(posedge ref_clk_i);
        ca <= 1'b0;
        cb <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
    endtask : cap

    // hang guard well above the run length
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        {rst_n_i, cyc, stb, we, a_drv, b_drv, ca, cb} = '0;
        {adr, a_val, b_val, wdat, sel} = '0;
        rdy = 1'b1;
        ce = 1'b1;
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        wb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h2);
        chk({a_oe_n, b_oe_n}, 2'b11);
        drv(1'b1, 8'h33, 1'b1, 8'hC5);
        cap(1'b1, 1'b1);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd[15:0], 16'hC533);
        for (int i = 0; i < 6; i++) begin
            drv(rows[i].ad, rows[i].av, rows[i].bd, rows[i].bv);
            wb(1'b1, 8'h00, {28'h0, rows[i].ctl});
            repeat (3) @(posedge ref_clk_i);
            chk({a_oe_n, b_oe_n}, rows[i].oe);
            if (!rows[i].oe[1]) chk(a_o, rows[i].ao);
            if (!rows[i].oe[0]) chk(b_o, rows[i].bo);
        end
        // select low lets both clocks rise together while B is driven
        drv(1'b1, 8'h69, 1'b0, 8'h00);
        wb(1'b1, 8'h00, 32'h3);
        repeat (3) @(posedge ref_clk_i);
        cap(1'b1, 1'b1);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd[15:0], 16'h6969);
        // both live directions on, then the far side lets go
        drv(1'b1, 8'h3C, 1'b0, 8'h00);
        wb(1'b1, 8'h00, 32'h1);
        // let both drivers take the far value before the far side lets go
        repeat (3) @(posedge ref_clk_i);
        drv(1'b0, 8'h00, 1'b0, 8'h00);
        repeat (5) @(posedge ref_clk_i);
        chk({a_bus, b_bus}, 16'h3C3C);
        // stalled reader: two records kept, third dropped
        wb(1'b1, 8'h00, 32'h2);
        rdy <= 1'b0;
        drv(1'b1, 8'h11, 1'b0, 8'h00);
        cap(1'b1, 1'b0);
        drv(1'b1, 8'h22, 1'b0, 8'h00);
        cap(1'b1, 1'b0);
        drv(1'b1, 8'h44, 1'b0, 8'h00);
        cap(1'b1, 1'b0);
        chk({cvld, cdat.b_hit, cdat.a_hit, cdat.a_data}, 11'h511);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd[3:2], 2'b11);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd[7:0], 8'h44);
        rdy <= 1'b1;
        @(posedge ref_clk_i);
        rdy <= 1'b0;
        @(posedge ref_clk_i);
        chk({cvld, cdat.a_data}, 9'h122);
        rdy <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        chk(cvld, 1'b0);
        wb(1'b1, 8'h08, 32'h7);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        // clock enable low: a capture pulse and new far data are ignored
        ce <= 1'b0;
        drv(1'b1, 8'h77, 1'b0, 8'h00);
        cap(1'b1, 1'b1);
        ce <= 1'b1;
        wb(1'b0, 8'h04, 32'h0);
        chk(rd[15:0], 16'h6944);
        end_of_test();
    end
endmodule : octal_registered_bus_transceiver_test

/* rtl/bus_transceiver.sv */
/*
 * Octal registered bus transceiver between an A bus and a B bus, with one
 * storage register per direction and a wishbone classic register port.
 * Assumes all pins, capture clocks included, are synchronous to ref_clk_i
 * and that the bench resolves each bus wire from the output enables.
 */
// What this block does
// - two eight-bit two-way ports, one register each
// - each capture clock rise loads its bus
// - captures see pin levels even while driving
// - select low forwards live, high forwards stored
// - select change switches output without glitch
// - enables drive B, A, or isolate both
// - live A to B, complemented when inverting
// - live B to A, complemented when inverting
// - stored A on B, changing only on capture
// - both stored directions drive at once
// - live both-way drive latches bus values
// - one-way live drive loads both registers alike, complemented when inverting
// - undriven side follows enables and selects
`timescale 1ns/1ps
`include "xcvr_cfg.svh"

module bus_transceiver
    import xcvr_pkg::*;
#(
    parameter int BUS_W = `XCVR_BUS_W,
    parameter int ADR_W = 8,
    parameter bit INVERTING = 1'b0
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [BUS_W-1:0] a_i,
    output logic [BUS_W-1:0] a_o,
    output logic a_oe_n_o,
    input wire logic [BUS_W-1:0] b_i,
    output logic [BUS_W-1:0] b_o,
    output logic b_oe_n_o,
    input wire logic a_side_capture_clock_i,
    input wire logic b_side_capture_clock_i,
    output logic cap_valid_o,
    output cap_s cap_data_o,
    input wire logic cap_ready_i
);

    localparam logic [BUS_W-1:0] INV_MASK = {BUS_W{INVERTING}};

    ctrl_s ctrl_ff;
    logic [BUS_W-1:0] a_store_ff;
    logic [BUS_W-1:0] b_store_ff;
    logic a_clk_q_ff;
    logic b_clk_q_ff;
    logic a_seen_ff;
    logic b_seen_ff;
    logic overrun_ff;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [BUS_W-1:0] a_o_ff;
    logic [BUS_W-1:0] b_o_ff;
    logic a_oe_n_ff;
    logic b_oe_n_ff;
    logic buf_ready;

    // capture clocks are plain synchronous inputs; one flop finds the edge
    wire a_rise = a_side_capture_clock_i & ~a_clk_q_ff;
    wire b_rise = b_side_capture_clock_i & ~b_clk_q_ff;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // held high so a clock already high at release is no edge
            a_clk_q_ff <= 1'b1;
            b_clk_q_ff <= 1'b1;
        end else if (ce_i) begin
            a_clk_q_ff <= a_side_capture_clock_i;
            b_clk_q_ff <= b_side_capture_clock_i;
        end
    end

    // storage loads from the pins, never gated by select or enable
    // the pins carry our own drive when enabled, so a one-way live
    // transfer lands in both registers once the bus has settled
    // no reset here: contents stay unknown until the first capture
    always_ff @(posedge ref_clk_i) begin
        if (ce_i && a_rise) begin
            a_store_ff <= a_i;
        end
        if (ce_i && b_rise) begin
            b_store_ff <= b_i;
        end
    end

    // source select picks live opposite bus or stored word per direction
    wire [BUS_W-1:0] nxt_b_o = (ctrl_ff.ab_sel ? a_store_ff : a_i)
                             ^ INV_MASK;
    wire [BUS_W-1:0] nxt_a_o = (ctrl_ff.ba_sel ? b_store_ff : b_i)
                             ^ INV_MASK;
    wire nxt_b_oe_n = ~ctrl_ff.ab_en;
    wire nxt_a_oe_n = ctrl_ff.ba_en_n;

    // every pin output is a flop, so a select change moves from one
    // clean word to the other with no mux hazard, at one cycle of latency
    // with both directions live the registered loop holds the bus level
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            a_o_ff <= '0;
            b_o_ff <= '0;
            a_oe_n_ff <= 1'b1;
            b_oe_n_ff <= 1'b1;
        end else if (ce_i) begin
            a_o_ff <= nxt_a_o;
            b_o_ff <= nxt_b_o;
            a_oe_n_ff <= nxt_a_oe_n;
            b_oe_n_ff <= nxt_b_oe_n;
        end
    end

    assign a_o = a_o_ff;
    assign b_o = b_o_ff;
    assign a_oe_n_o = a_oe_n_ff;
    assign b_oe_n_o = b_oe_n_ff;

    // wishbone decode; a request is acked one edge after it is seen
    wire req = wb_cyc_i & wb_stb_i;
    wire take = req & ~ack_ff;
    wire wr_fire = req & wb_we_i & ack_ff;
    wire hit_ctrl = wb_adr_i == ADR_W'(`XCVR_OFS_CTRL);
    wire hit_store = wb_adr_i == ADR_W'(`XCVR_OFS_STORE);
    wire hit_status = wb_adr_i == ADR_W'(`XCVR_OFS_STATUS);
    wire wr_ctrl = wr_fire & hit_ctrl & wb_sel_i[0];
    wire wr_status = wr_fire & hit_status & wb_sel_i[0];

    // status word; unmapped addresses read zero and are acked
    wire [3:0] status_word = {~buf_ready, overrun_ff, b_seen_ff, a_seen_ff};
    wire [31:0] rd_data = hit_ctrl ? {28'h0000000, ctrl_ff}
                        : hit_store ? 32'({b_store_ff, a_store_ff})
                        : hit_status ? {28'h0000000, status_word}
                        : 32'h00000000;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
        end else if (ce_i) begin
            ack_ff <= take;
            if (take) begin
                dat_ff <= rd_data;
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    // software writes take effect at the edge where the master sees ack
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_ff <= ctrl_s'(`XCVR_RST_CTRL);
        end else if (ce_i && wr_ctrl) begin
            ctrl_ff <= ctrl_s'(wb_dat_i[`XCVR_CTRL_W-1:0]);
        end
    end

    // sticky flags: write one clears, a same-cycle event wins
    wire clr_a = wr_status & wb_dat_i[`XCVR_STS_A_SEEN];
    wire clr_b = wr_status & wb_dat_i[`XCVR_STS_B_SEEN];
    wire clr_o = wr_status & wb_dat_i[`XCVR_STS_OVERRUN];
    wire push_req = a_rise | b_rise;
    wire lost = push_req & ~buf_ready;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            a_seen_ff <= 1'b0;
            b_seen_ff <= 1'b0;
            overrun_ff <= 1'b0;
        end else if (ce_i) begin
            a_seen_ff <= a_rise | (a_seen_ff & ~clr_a);
            b_seen_ff <= b_rise | (b_seen_ff & ~clr_b);
            overrun_ff <= lost | (overrun_ff & ~clr_o);
        end
    end

    // each capture also posts a record; a stalled reader fills the buffer
    // and a capture that finds it full is flagged, since the register
    // itself must still load on every edge
    cap_s cap_in;
    assign cap_in = '{b_hit: b_rise, a_hit: a_rise,
                      b_data: b_i, a_data: a_i};

    cap_buffer #(
        .WIDTH($bits(cap_s)),
        .DEPTH(`XCVR_BUF_DEPTH)
    ) u_cap_buffer (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .in_valid_i(push_req),
        .in_ready_o(buf_ready),
        .in_data_i(cap_in),
        .out_valid_o(cap_valid_o),
        .out_ready_i(cap_ready_i),
        .out_data_o(cap_data_o)
    );

    // primed after the first capture; before it the content is legally
    // unknown, so the hold checks would only compare unknowns
    logic a_primed_ff;
    logic b_primed_ff;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            a_primed_ff <= 1'b0;
            b_primed_ff <= 1'b0;
        end else if (ce_i) begin
            a_primed_ff <= a_primed_ff | a_rise;
            b_primed_ff <= b_primed_ff | b_rise;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence seq_a_cap;
        ce_i && a_rise;
    endsequence

    sequence seq_b_cap;
        ce_i && b_rise;
    endsequence

    AST_A_LOAD: assert property (
        seq_a_cap |=> a_store_ff == $past(a_i))
        else $error("A register missed a capture");
    AST_B_LOAD: assert property (
        seq_b_cap |=> b_store_ff == $past(b_i))
        else $error("B register missed a capture");
    AST_A_HOLD: assert property (
        a_primed_ff && ce_i && !a_rise |=> $stable(a_store_ff))
        else $error("A register changed without a capture edge");
    AST_DRIVE_EN: assert property (
        ce_i |=> b_oe_n_o == !$past(ctrl_ff.ab_en)
              && a_oe_n_o == $past(ctrl_ff.ba_en_n))
        else $error("drive enable does not follow control");
    AST_LIVE_AB: assert property (
        ce_i && !ctrl_ff.ab_sel |=> b_o == ($past(a_i) ^ INV_MASK))
        else $error("live A data not on B output");
    AST_LIVE_BA: assert property (
        ce_i && !ctrl_ff.ba_sel |=> a_o == ($past(b_i) ^ INV_MASK))
        else $error("live B data not on A output");
    AST_STORED_BOTH: assert property (
        ce_i && ctrl_ff.ab_sel && ctrl_ff.ba_sel
        |=> b_o == ($past(a_store_ff) ^ INV_MASK)
         && a_o == ($past(b_store_ff) ^ INV_MASK))
        else $error("stored words not driven both ways");
    AST_FREEZE: assert property (
        !ce_i |=> $stable(a_o) && $stable(b_o) && $stable(a_store_ff))
        else $error("state moved while clock enable low");
    AST_SEEN_SET_WINS: assert property (
        seq_a_cap ##1 ce_i |-> a_seen_ff)
        else $error("capture flag lost to a clear");

    // the B pins carry our own live copy of A, far side silent
    sequence seq_ab_on_b;
        !b_oe_n_o && b_i == b_o && b_o == (a_i ^ INV_MASK);
    endsequence

    // both ports carry our own drive, each the image of the other
    sequence seq_loop_closed;
        !a_oe_n_o && !b_oe_n_o && a_i == a_o && b_i == b_o
        && a_o == (b_o ^ INV_MASK);
    endsequence

    AST_B_HOLD: assert property (
        b_primed_ff && ce_i && !b_rise |=> $stable(b_store_ff))
        else $error("B register changed without a capture edge");
    AST_STORED_AB: assert property (
        ce_i && ctrl_ff.ab_sel |=> b_o == ($past(a_store_ff) ^ INV_MASK))
        else $error("stored A word not on B output");
    AST_STORED_BA: assert property (
        ce_i && ctrl_ff.ba_sel |=> a_o == ($past(b_store_ff) ^ INV_MASK))
        else $error("stored B word not on A output");
    AST_LOAD_WHEN_FULL: assert property (
        seq_a_cap ##0 !buf_ready |=> a_store_ff == $past(a_i) && overrun_ff)
        else $error("full record buffer blocked a capture");
    AST_ONE_WAY_BOTH: assert property (
        seq_a_cap ##0 seq_b_cap ##0 seq_ab_on_b
        |=> b_store_ff == (a_store_ff ^ INV_MASK))
        else $error("one-way capture left registers unlike");
    AST_LOOP_HOLD: assert property (
        ce_i && !ctrl_ff.ab_sel && !ctrl_ff.ba_sel ##0 seq_loop_closed
        |=> $stable(a_o) && $stable(b_o))
        else $error("both-way live drive did not hold the buses");

endmodule : bus_transceiver

/* rtl/cap_buffer.sv */
/*
 * Small shift buffer with valid and ready on both sides; the head entry
 * and both handshake outputs come straight from flip-flops.
 * Assumes one clock, active-low async reset and a clock enable.
 */
`timescale 1ns/1ps

module cap_buffer #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    logic [DEPTH-1:0] vld_ff;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [DEPTH-1:0] shifted;
    logic [DEPTH-1:0] land;
    wire push = in_valid_i & ~vld_ff[DEPTH-1];
    wire pop = vld_ff[0] & out_ready_i;

    genvar gi;
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
        logic up_vld;
        logic [WIDTH-1:0] up_dat;
        // the last slot sees an empty slot above it, so every flop
        // keeps a single driver and no padding entry is needed
        if (gi == DEPTH-1) begin : g_top
            assign up_vld = 1'b0;
            assign up_dat = '0;
        end else begin : g_mid
            assign up_vld = vld_ff[gi+1];
            assign up_dat = mem_ff[gi+1];
        end
        // occupancy after a pop moves every entry one slot down
        assign shifted[gi] = pop ? up_vld : vld_ff[gi];
        if (gi == 0) begin : g_first
            assign land[gi] = push & ~shifted[gi];
        end else begin : g_rest
            assign land[gi] = push & ~shifted[gi] & shifted[gi-1];
        end
        // data has no reset; only the valid flags carry meaning
        always_ff @(posedge ref_clk_i) begin
            if (ce_i) begin
                mem_ff[gi] <= land[gi] ? in_data_i
                            : (pop ? up_dat : mem_ff[gi]);
            end
        end
        always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                vld_ff[gi] <= 1'b0;
            end else if (ce_i) begin
                vld_ff[gi] <= shifted[gi] | land[gi];
            end
        end
    end

    assign out_valid_o = vld_ff[0];
    assign out_data_o = mem_ff[0];
    // ready is the registered inverse of the last slot being taken
    assign in_ready_o = ~vld_ff[DEPTH-1];

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_BUF_HOLD: assert property (
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
        else $error("buffer head changed while stalled");
    AST_BUF_FULL_STALL: assert property (
        !in_ready_o |-> vld_ff[0])
        else $error("buffer refuses input while head is empty");

endmodule : cap_buffer

/* rtl/xcvr_cfg.svh */
/*
 * Constants of the registered bus transceiver: register offsets, field
 * positions, reset values and buffer sizing.
 * Assumes it is included by its bare name, by the package and the top.
 */
`ifndef XCVR_CFG_SVH
`define XCVR_CFG_SVH

// data bus width of each port
`define XCVR_BUS_W 8

// register byte offsets on the wishbone bus
`define XCVR_OFS_CTRL 8'h00
`define XCVR_OFS_STORE 8'h04
`define XCVR_OFS_STATUS 8'h08

// control register field positions
`define XCVR_CTRL_AB_EN 0
`define XCVR_CTRL_BA_EN_N 1
`define XCVR_CTRL_AB_SEL 2
`define XCVR_CTRL_BA_SEL 3
`define XCVR_CTRL_W 4

// control reset value: both ports isolated, live data selected
`define XCVR_RST_CTRL 4'h2

// status register field positions
`define XCVR_STS_A_SEEN 0
`define XCVR_STS_B_SEEN 1
`define XCVR_STS_OVERRUN 2
`define XCVR_STS_BUF_FULL 3

// capture record buffer depth
`define XCVR_BUF_DEPTH 2

`endif

/* rtl/xcvr_pkg.sv */
/*
 * Types shared by the registered bus transceiver and its test bench.
 * Assumes xcvr_cfg.svh is on the include path.
 */
`include "xcvr_cfg.svh"

package xcvr_pkg;

    // control fields, packed in register bit order
    typedef struct packed {
        logic ba_sel;
        logic ab_sel;
        logic ba_en_n;
        logic ab_en;
    } ctrl_s;

    // one capture record: which registers loaded and what they took
    typedef struct packed {
        logic b_hit;
        logic a_hit;
        logic [`XCVR_BUS_W-1:0] b_data;
        logic [`XCVR_BUS_W-1:0] a_data;
    } cap_s;

endpackage : xcvr_pkg
